// ---- src/conv_decode_defs.vh ----
// Build configuration, register map and field constants of the convolutional decoder
`ifndef CONV_DECODE_DEFS_VH
`define CONV_DECODE_DEFS_VH

// Code structure
`define CFG_K             3
`define CFG_RATE_N        2
`define CFG_PUNCTURED     0
`define CFG_NPOLY         ((`CFG_PUNCTURED != 0) ? 2 : `CFG_RATE_N)
`define CFG_TB_LEN        15
`define CFG_PM_W          12

// Generator polynomials, each CFG_K bits wide; bit 0 taps the newest input
`define GP_FIRST          3'h7
`define GP_SECOND         3'h5
`define GP_THIRD          3'h0
`define GP_FOURTH         3'h0
`define GP_FIFTH          3'h0
`define GP_SIXTH          3'h0
`define GP_SEVENTH        3'h0

// Implementation method: 0 parallel, 1 hybrid
`define CFG_HYBRID        0
`define CFG_HYB_INDEX     1

// Inputs: soft selection forced when punctured
`define CFG_SOFT_REQ      1
`define CFG_SOFT          ((`CFG_PUNCTURED != 0) ? 1 : `CFG_SOFT_REQ)
`define CFG_SOFT_W        3
`define CFG_SIGNED        1

// Error rate monitor
`define CFG_MON_EN        1
`define CFG_MON_PERIOD    4

// APB register offsets
`define OFS_CTRL          12'h000
`define OFS_STATUS        12'h004
`define OFS_ERRCNT        12'h008
`define OFS_DECCNT        12'h00c
`define OFS_CONFIG        12'h010

// Control fields and reset value
`define CTRL_ENABLE_BIT   0
`define CTRL_RESTART_BIT  1
`define CTRL_RESET        1'b0

`endif

// ---- src/convolutional_decode_core.v ----
// Register-exchange convolutional decoder with APB control and error rate monitor
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "conv_decode_defs.vh"

// Operation
// R1: Punctured builds always use exactly two generator polynomials.
// R2: Unpunctured builds use as many polynomials as the rate denominator, up to seven.
// R3: Each generator polynomial is a vector as wide as the constraint length.
// R4: Parallel method delivers one decoded bit every clock cycle.
// R5: Hybrid method takes two to the hybrid index cycles per decoded bit.
// R6: Punctured builds accept only soft symbols; supplier must send soft values.
// R7: Soft samples read as sign-magnitude or unsigned offset per data type.
// R8: Error rate monitor exists only when selected at build time.
// R9: Monitor accumulates from zero over two to the period clock cycles.
// R10: At window end the count appears on the output, held until next window.
// R11: After publishing, accumulator clears and a new window starts immediately.
// R12: An error is a hard-sliced coded bit differing from re-encoded output.
// R13: Soft sample width is a build parameter from three to eight bits.
// R14: Monitor period is a build parameter from four to thirty-two.
module convolutional_decode_core (
    // Clock and reset
    input  wire                              clk,
    input  wire                              reset_n,
    // APB slave
    input  wire                              psel,
    input  wire                              penable,
    input  wire                              pwrite,
    input  wire [11:0]                       paddr,
    input  wire [31:0]                       pwdata,
    output reg  [31:0]                       prdata,
    output wire                              pready,
    output reg                               pslverr,
    // Coded symbol stream
    input  wire                              sym_valid,
    output wire                              sym_ready,
    input  wire [`CFG_NPOLY*`CFG_SOFT_W-1:0] sym_data,
    // Decoded bit stream
    output reg                               dec_valid,
    output reg                               dec_bit,
    // Error rate
    output wire [31:0]                       error_rate_count,
    output wire                              error_window_done
);
    localparam K    = `CFG_K;
    localparam NP   = `CFG_NPOLY;
    localparam W    = `CFG_SOFT_W;
    localparam TB   = `CFG_TB_LEN;
    localparam PMW  = `CFG_PM_W;
    // Metrics wrap, so PMW only bounds the spread between states, not their growth
    localparam S    = 1 << (K - 1);
    localparam [W-1:0] MAXC = {W{1'b1}};
    localparam [7:0]   CYC_LAST = (`CFG_HYBRID != 0) ? ((8'h1 << `CFG_HYB_INDEX) - 8'h1) : 8'h0;
    localparam [7*K-1:0] GP_ALL = {`GP_SEVENTH, `GP_SIXTH, `GP_FIFTH, `GP_FOURTH,
                                   `GP_THIRD, `GP_SECOND, `GP_FIRST}; // R3

    // Map a sample to a confidence that the coded bit is one
    function [W-1:0] conf;
        input [W-1:0] v;
        begin
            if (`CFG_SOFT == 0)
                conf = v[0] ? MAXC : {W{1'b0}};
            else if (`CFG_SIGNED != 0)
                conf = v[W-1] ? {1'b1, v[W-2:0]} : {1'b0, ~v[W-2:0]}; // R7
            else
                conf = v;                                           // R7
        end
    endfunction

    // Coded bits for one encoder register image; only NP polynomials take part
    function [6:0] encode;
        input [K-1:0] r;
        integer j;
        begin
            encode = 7'h0;
            for (j = 0; j < NP; j = j + 1)
                encode[j] = ^(r & GP_ALL[j*K +: K]);                // R1 R2
        end
    endfunction

    function [PMW-1:0] bmetric;
        input [K-1:0]    r;
        input [NP*W-1:0] c;
        reg   [6:0]      e;
        integer j;
        begin
            e = encode(r);
            bmetric = {PMW{1'b0}};
            for (j = 0; j < NP; j = j + 1)
                bmetric = bmetric + {{(PMW-W){1'b0}},
                          (e[j] ? (MAXC - c[j*W +: W]) : c[j*W +: W])};
        end
    endfunction

    // Control state
    reg             enable_ff;
    reg             restart_ff;
    reg  [7:0]      pace_ff;
    reg  [7:0]      fill_ff;
    reg  [31:0]     deccnt_ff;
    reg  [S*PMW-1:0] pm_ff;
    reg  [S*TB-1:0]  surv_ff;
    reg  [TB*NP-1:0] rx_hist_ff;
    reg  [NP-1:0]   ber_rx_ff;
    reg  [K-2:0]    dh_ff;
    reg             err_valid_ff;
    reg  [2:0]      err_bits_ff;

    wire [NP*W-1:0]  cv;
    wire [NP-1:0]    rx_hard;
    wire [S*PMW-1:0] nxt_pm;
    wire [S*TB-1:0]  nxt_surv;
    // Output starts once every survivor word holds real decisions
    wire             filled = (fill_ff == TB[7:0]);

    // Sample acceptance is the only pacing point: hybrid builds open it once per period
    assign sym_ready = enable_ff && (pace_ff == 8'h0);             // R4 R5
    wire   step      = sym_valid && sym_ready;

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : lane
            assign cv[g*W +: W] = conf(sym_data[g*W +: W]);        // R6 R13
            assign rx_hard[g]   = cv[g*W + W - 1];                 // R12
        end
        // Survivor words: newest decision in bit 0, the one handed out in bit TB-1
        for (g = 0; g < S; g = g + 1) begin : acs
            localparam [K-1:0] R0 = g;
            localparam [K-1:0] R1 = g + S;
            localparam integer P0 = g >> 1;
            localparam integer P1 = (g >> 1) + S / 2;
            wire [PMW-1:0] m0 = pm_ff[P0*PMW +: PMW] + bmetric(R0, cv);
            wire [PMW-1:0] m1 = pm_ff[P1*PMW +: PMW] + bmetric(R1, cv);
            wire [PMW-1:0] d  = m0 - m1;
            // Wrapping metrics compared by difference sign, so no renormalisation is needed
            wire           sel = ~d[PMW-1];
            assign nxt_pm[g*PMW +: PMW] = sel ? m1 : m0;
            assign nxt_surv[g*TB +: TB] = sel ?
                   {surv_ff[P1*TB +: TB-1], R0[0]} : {surv_ff[P0*TB +: TB-1], R0[0]};
        end
    endgenerate

    // Pacing, trellis update and decoded output
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pace_ff    <= 8'h0;
            fill_ff    <= 8'h0;
            deccnt_ff  <= 32'h0;
            pm_ff      <= {(S*PMW){1'b0}};
            surv_ff    <= {(S*TB){1'b0}};
            rx_hist_ff <= {(TB*NP){1'b0}};
            ber_rx_ff  <= {NP{1'b0}};
            dec_valid  <= 1'b0;
            dec_bit    <= 1'b0;
        end else if (restart_ff) begin
            pace_ff    <= 8'h0;
            fill_ff    <= 8'h0;
            pm_ff      <= {(S*PMW){1'b0}};
            surv_ff    <= {(S*TB){1'b0}};
            rx_hist_ff <= {(TB*NP){1'b0}};
            ber_rx_ff  <= {NP{1'b0}};
            dec_valid  <= 1'b0;
        end else begin
            dec_valid <= step && filled;
            if (step) begin
                pace_ff    <= CYC_LAST;                                   // R5
                pm_ff      <= nxt_pm;
                surv_ff    <= nxt_surv;
                rx_hist_ff <= {rx_hist_ff[(TB-1)*NP-1:0], rx_hard};
                ber_rx_ff  <= rx_hist_ff[(TB-2)*NP +: NP];
                // Fixed-state traceback from state zero: cheaper than a best-state search
                dec_bit    <= nxt_surv[TB-1];                             // R4
                if (!filled)
                    fill_ff <= fill_ff + 8'h1;
                else
                    deccnt_ff <= deccnt_ff + 32'h1;
            end else if (pace_ff != 8'h0) begin
                pace_ff <= pace_ff - 8'h1;                                // R5
            end
        end
    end

    // Re-encode decoded bits and compare with delayed hard decisions
    wire [6:0] expect_bits = encode({dh_ff, dec_bit});
    wire [NP-1:0] diff = expect_bits[NP-1:0] ^ ber_rx_ff;
    reg  [2:0] diff_cnt;
    integer i;
    always @* begin
        diff_cnt = 3'h0;
        for (i = 0; i < NP; i = i + 1)
            diff_cnt = diff_cnt + {2'b00, diff[i]};                       // R12
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dh_ff        <= {(K-1){1'b0}};
            err_valid_ff <= 1'b0;
            err_bits_ff  <= 3'h0;
        end else if (restart_ff) begin
            // A restart begins a fresh code stream, so re-encoder history starts at zero
            dh_ff        <= {(K-1){1'b0}};
            err_valid_ff <= 1'b0;
        end else begin
            err_valid_ff <= dec_valid;
            if (dec_valid) begin
                err_bits_ff <= diff_cnt;                                  // R12
                dh_ff       <= {dh_ff[K-3:0], dec_bit};
            end
        end
    end

    generate
        if (`CFG_MON_EN != 0) begin : mon
            error_rate_monitor u_mon (                                    // R8 R14
                .clk              (clk),
                .reset_n          (reset_n),
                .err_valid        (err_valid_ff),
                .err_bits         (err_bits_ff),
                .error_rate_count (error_rate_count),
                .window_done      (error_window_done)
            );
        end else begin : no_mon
            // Port stays for a fixed pinout but carries nothing in this build
            assign error_rate_count  = 32'h0;                             // R8
            assign error_window_done = 1'b0;
        end
    endgenerate

    // APB slave: zero wait states, read data captured in the setup cycle
    assign pready = 1'b1;
    wire setup   = psel && !penable;
    wire wr_acc  = psel && penable && pwrite;
    wire hit_ctrl   = (paddr == `OFS_CTRL);
    wire hit_status = (paddr == `OFS_STATUS);
    wire hit_errcnt = (paddr == `OFS_ERRCNT);
    wire hit_deccnt = (paddr == `OFS_DECCNT);
    wire hit_config = (paddr == `OFS_CONFIG);
    wire mapped     = hit_ctrl || hit_status || hit_errcnt || hit_deccnt || hit_config;

    // Build configuration word; the period field is six bits so that 32 fits
    localparam [3:0]  CFG_K_F    = `CFG_K;
    localparam [2:0]  CFG_NP_F   = NP;
    localparam [3:0]  CFG_W_F    = `CFG_SOFT_W;
    localparam [0:0]  CFG_SOFT_F = `CFG_SOFT;
    localparam [0:0]  CFG_SGN_F  = `CFG_SIGNED;
    localparam [0:0]  CFG_HYB_F  = `CFG_HYBRID;
    localparam [3:0]  CFG_HIX_F  = `CFG_HYB_INDEX;
    localparam [0:0]  CFG_MON_F  = `CFG_MON_EN;
    localparam [5:0]  CFG_PER_F  = `CFG_MON_PERIOD;
    localparam [31:0] CFG_WORD   = {
        2'h0,
        CFG_PER_F,
        3'h0,
        CFG_MON_F,
        CFG_HIX_F,
        1'b0,
        CFG_HYB_F,
        CFG_SGN_F,
        CFG_SOFT_F,
        CFG_W_F,
        1'b0,
        CFG_NP_F,
        CFG_K_F
    };

    reg  [31:0] rd_mux;

    always @* begin
        case (paddr)
            `OFS_CTRL:   rd_mux = {31'h0, enable_ff};
            `OFS_STATUS: rd_mux = {16'h0, fill_ff, 6'h0, enable_ff, filled};
            `OFS_ERRCNT: rd_mux = error_rate_count;
            `OFS_DECCNT: rd_mux = deccnt_ff;
            `OFS_CONFIG: rd_mux = CFG_WORD;
            default:     rd_mux = 32'h0;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata     <= 32'h0;
            pslverr    <= 1'b0;
            enable_ff  <= `CTRL_RESET;
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= 1'b0;
            if (setup) begin
                prdata  <= pwrite ? 32'h0 : rd_mux;
                pslverr <= !mapped;
            end
            // Unmapped and read-only offsets ignore writes; pslverr flags the former
            if (wr_acc && hit_ctrl) begin
                enable_ff  <= pwdata[`CTRL_ENABLE_BIT];
                restart_ff <= pwdata[`CTRL_RESTART_BIT];
            end
        end
    end
endmodule

// ---- src/error_rate_monitor.v ----
// Windowed error accumulator that publishes one count per window
`timescale 1ns/1ps
`include "conv_decode_defs.vh"

module error_rate_monitor (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Error events from the re-encoder
    input  wire        err_valid,
    input  wire [2:0]  err_bits,
    // Result
    output reg  [31:0] error_rate_count,
    output reg         window_done
);
    localparam [32:0] WIN_LAST = (33'h1 << `CFG_MON_PERIOD) - 33'h1;

    reg  [31:0] win_ff;
    reg  [31:0] acc_ff;
    wire [31:0] inc = err_valid ? {29'h0, err_bits} : 32'h0;
    wire        last = ({1'b0, win_ff} == WIN_LAST);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            win_ff           <= 32'h0;
            acc_ff           <= 32'h0;
            error_rate_count <= 32'h0;
            window_done      <= 1'b0;
        end else begin
            window_done <= last;
            if (last) begin
                win_ff           <= 32'h0;                 // R11
                error_rate_count <= acc_ff + inc;          // R10
                acc_ff           <= 32'h0;                 // R11
            end else begin
                win_ff <= win_ff + 32'h1;                  // R9
                acc_ff <= acc_ff + inc;                    // R9
            end
        end
    end
endmodule

// ---- testbench/convolutional_decode_core_test.sv ----
// Self-checking bench: APB register access and a coded stream with one injected error
`timescale 1ns/1ps
`include "conv_decode_defs.vh"
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module convolutional_decode_core_test;
    reg         clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h0;
    reg  [31:0] pwdata = 32'h0;
    reg         run = 1'b0, slow = 1'b0;
    reg  [15:0] inject_at = 16'h0028;
    wire [31:0] prdata, error_rate_count;
    wire [5:0]  sym_data;
    wire        pready, pslverr, sym_valid, sym_ready, dec_valid, dec_bit, cur_bit, wdone;
    int         n_errors = 0, tests_run = 0, n_acc = 0, n_dec = 0, err_sum = 0;
    bit         sent_q[$];
    reg  [31:0] rd;
    reg         re;

    always #4 clk = ~clk;

    convolutional_decode_core u_convolutional_decode_core (.clk(clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sym_valid(sym_valid),
        .sym_ready(sym_ready), .sym_data(sym_data), .dec_valid(dec_valid),
        .dec_bit(dec_bit), .error_rate_count(error_rate_count), .error_window_done(wdone));
    symbol_source u_symbol_source (.clk(clk), .reset_n(reset_n), .run(run), .slow(slow),
        .inject_at(inject_at), .sym_ready(sym_ready), .sym_valid(sym_valid),
        .sym_data(sym_data), .cur_bit(cur_bit));

    // Symbol 0 only fills the trellis; decoded bit k is the bit of symbol k+1
    always @(posedge clk) begin
        if (sym_valid && sym_ready) begin
            sent_q.push_back(cur_bit);
            n_acc++;
        end
        if (dec_valid) begin
            `CHECK("dec_bit", sent_q[n_dec + 1], dec_bit)
            n_dec++;
        end
        if (wdone)
            err_sum += error_rate_count;
    end

    task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
        int t;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1)
            n_errors++;
        rd = prdata;
        re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd_chk(input [11:0] a, input [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHECK(nm, e, rd)
        `CHECK("pslverr", (a > 12'h010), re)
    endtask

    task automatic wait_acc(input int n);
        int t;
        t = 0;
        while (n_acc < n && t < 4000) begin
            @(posedge clk);
            t++;
        end
        if (n_acc < n)
            n_errors++;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report;
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(12'h000, 32'h0, "ctrl reset");
        rd_chk(12'h004, 32'h0, "status reset");
        rd_chk(12'h00c, 32'h0, "deccnt reset");
        rd_chk(12'h010, 32'h04113323, "config");
        apb(1'b1, 12'h010, 32'h0);
        rd_chk(12'h010, 32'h04113323, "config ro");
        rd_chk(12'h020, 32'h0, "unmapped");
        run <= 1'b1;
        repeat (20) @(posedge clk);
        `CHECK("accepted while disabled", 0, n_acc)
        $display("test registers done");
        apb(1'b1, 12'h000, 32'h1);
        rd_chk(12'h000, 32'h1, "ctrl enable");
        wait_acc(100);
        slow <= 1'b1;
        wait_acc(160);
        run <= 1'b0;
        repeat (60) @(posedge clk);
        `CHECK("decoded count", n_acc - 15, n_dec)
        `CHECK("window error total", 1, err_sum)
        rd_chk(12'h008, 32'h0, "errcnt idle");
        rd_chk(12'h00c, n_dec, "deccnt");
        apb(1'b0, 12'h004, 32'h0);
        `CHECK("status filled", 2'b11, rd[1:0])
        $display("test stream done");
        apb(1'b1, 12'h000, 32'h3);
        rd_chk(12'h000, 32'h1, "ctrl restart reads 0");
        apb(1'b0, 12'h004, 32'h0);
        `CHECK("status after restart", 16'h0002, rd[15:0])
        apb(1'b1, 12'h000, 32'h0);
        rd_chk(12'h000, 32'h0, "ctrl disable");
        $display("test restart done");
        final_report;
    end
endmodule

// ---- testbench/decode_core_properties.sv ----
// Concurrent checks on the decoder's ports
`timescale 1ns/1ps
`include "conv_decode_defs.vh"

module decode_core_properties (
    // Clock and reset
    input wire                              clk,
    input wire                              reset_n,
    // APB
    input wire                              psel,
    input wire                              penable,
    input wire                              pwrite,
    input wire [11:0]                       paddr,
    input wire [31:0]                       pwdata,
    input wire [31:0]                       prdata,
    input wire                              pready,
    input wire                              pslverr,
    // Streams and monitor
    input wire                              sym_valid,
    input wire                              sym_ready,
    input wire [`CFG_NPOLY*`CFG_SOFT_W-1:0] sym_data,
    input wire                              dec_valid,
    input wire                              dec_bit,
    input wire [31:0]                       error_rate_count,
    input wire                              error_window_done
);
    localparam int WIN = 1 << `CFG_MON_PERIOD;
    int gap_ff;
    int idle_ff;
    logic seen_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Window spacing and idle time measured apart from the design's own counter
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff  <= 0;
            idle_ff <= 0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= error_window_done ? 0 : gap_ff + 1;
            idle_ff <= dec_valid ? 0 : (idle_ff < 100 ? idle_ff + 1 : idle_ff);
            seen_ff <= seen_ff | error_window_done;
        end
    end

    dec_after_accept_a: assert property (dec_valid |-> $past(sym_valid && sym_ready))
        else $error("decoded bit without an accepted symbol");
    ready_back_to_back_a: assert property (
        (sym_valid && sym_ready && !(psel && penable && pwrite)) |=> sym_ready)
        else $error("symbol input not ready on the following cycle");
    window_gap_a: assert property ((seen_ff && gap_ff != WIN - 1) |-> !error_window_done)
        else $error("window end at the wrong spacing");
    window_next_a: assert property (error_window_done |-> ##16 error_window_done)
        else $error("next window end missing");
    count_held_a: assert property (!error_window_done |-> $stable(error_rate_count))
        else $error("error count moved between window ends");
    errcnt_mirror_a: assert property (
        (psel && !penable && !pwrite && paddr == 12'h008) |=> prdata == $past(error_rate_count))
        else $error("error count register differs from output");
    idle_zero_a: assert property (
        (error_window_done && idle_ff >= 24) |-> error_rate_count == 32'h0)
        else $error("stale errors published after idle window");
    ctrl_disable_a: assert property (
        (psel && penable && pwrite && paddr == 12'h000 && !pwdata[0]) |=> !sym_ready)
        else $error("symbol input still ready after disable");
    config_value_a: assert property (
        (psel && !penable && !pwrite && paddr == 12'h010) |=> prdata == 32'h04113323)
        else $error("build configuration word wrong");

    cover property (dec_valid);
    cover property (error_window_done && error_rate_count != 32'h0);
    cover property (sym_valid && !sym_ready);
endmodule

bind convolutional_decode_core decode_core_properties u_props (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_data(sym_data),
    .dec_valid(dec_valid), .dec_bit(dec_bit), .error_rate_count(error_rate_count),
    .error_window_done(error_window_done));

// ---- testbench/symbol_source.sv ----
// Upstream model: encodes a fixed bit pattern into soft sign-magnitude symbols
`timescale 1ns/1ps
`include "conv_decode_defs.vh"

module symbol_source (
    // Clock and reset
    input  wire                              clk,
    input  wire                              reset_n,
    // Control from the bench
    input  wire                              run,
    input  wire                              slow,
    input  wire [15:0]                       inject_at,
    // Symbol stream
    input  wire                              sym_ready,
    output reg                               sym_valid,
    output wire [`CFG_NPOLY*`CFG_SOFT_W-1:0] sym_data,
    output wire                              cur_bit
);
    reg  [15:0] idx_ff;
    reg  [1:0]  hist_ff;
    reg  [1:0]  pace_ff;
    wire [2:0]  taps = {hist_ff, cur_bit};
    wire        c0   = ^(taps & `GP_FIRST) ^ (idx_ff == inject_at);
    wire        c1   = ^(taps & `GP_SECOND);
    wire [5:0]  enc  = {c1, 2'b11, c0, 2'b11};
    assign cur_bit  = idx_ff[0] ^ idx_ff[3] ^ (idx_ff[2] & idx_ff[1]);
    // Idle lines carry the inverse so a decoder reading them unqualified goes wrong
    assign sym_data = sym_valid ? enc : ~enc;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idx_ff    <= 16'h0;
            hist_ff   <= 2'h0;
            pace_ff   <= 2'h0;
            sym_valid <= 1'b0;
        end else begin
            pace_ff <= pace_ff + 2'h1;
            if (sym_valid && sym_ready) begin
                idx_ff    <= idx_ff + 16'h1;
                hist_ff   <= {hist_ff[0], cur_bit};
                sym_valid <= run && !slow;
            end else if (!sym_valid) begin
                sym_valid <= run && (!slow || pace_ff == 2'h3);
            end
        end
    end
endmodule
